// ===== bcc_regs.sv
// buck channel three control bank behind an i2c target port
`timescale 1ns/1ns
module bcc_regs
	import bcc_pkg::*;
#(
	parameter logic [6:0] I2C_ADDR = I2C_ADDR_DEFAULT,
	parameter logic [CODE_W-1:0] STANDBY_RESET = 6'h00,
	parameter logic [CODE_W-1:0] NORMAL_RESET = 6'h00,
	parameter logic RANGE_RESET = 1'h0,
	parameter logic ENABLE_RESET = 1'h0,
	parameter logic UNMASK_RESET = 1'h0,
	// filler values are arbitrary
	parameter logic [1:0] FILL_STANDBY = 2'h0,
	parameter logic [7:0] FILL_WHOLE = 8'h00,
	parameter logic [4:0] FILL_CTRL = 5'h00,
	parameter logic FILL_NORMAL = 1'h0
)
(
	input wire logic SYS_CLK,
	input wire logic RSTN,
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	input wire logic VOLTAGE_SELECT_PIN,
	input wire logic EXTERNAL_CHANNEL_ENABLE,
	input wire logic POWER_GOOD_IN,
	output logic CHANNEL_ON,
	output logic [CODE_W-1:0] ACTIVE_VOLTAGE_CODE,
	output logic RANGE_SELECT,
	output logic FAULT_UNMASK,
	output logic [MV_W-1:0] TARGET_MV,
	output logic ADJUSTABLE_MODE
);
	typedef struct packed {
		bcc_i2c_state_type st;
		logic [3:0] cnt;
		logic [7:0] sr;
		logic [7:0] ptr;
		logic rw;
		logic ptr_done;
		logic nack;
		logic scl_d1;
		logic sda_d1;
		logic sda_oe;
		logic sda_out;
		logic [CODE_W-1:0] standby_voltage_code;
		logic [CODE_W-1:0] normal_voltage_code;
		logic range_select;
		logic fault_unmask;
		logic enable;
		logic ch_on;
		logic [CODE_W-1:0] code_out;
		logic range_out;
		logic unmask_out;
		logic [MV_W-1:0] mv;
		logic adj;
	} bcc_regs_state_type;

	bcc_regs_state_type q;
	bcc_regs_state_type d;
	logic [SYNC_W-1:0] pins_raw;
	logic [SYNC_W-1:0] pins;
	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic [7:0] rd_now;

	bcc_dec_if dec_bus();

	assign pins_raw = {POWER_GOOD_IN, EXTERNAL_CHANNEL_ENABLE, VOLTAGE_SELECT_PIN, SDA_IN, SCL_IN};

	bcc_sync u_sync (
		.clk(SYS_CLK),
		.rst_n(RSTN),
		.din(pins_raw),
		.dout(pins)
	);

	bcc_vdec u_vdec (
		.clk(SYS_CLK),
		.rst_n(RSTN),
		.dec(dec_bus.decoder)
	);

	assign dec_bus.code = q.code_out;
	assign dec_bus.range_select = q.range_out;

	// read image: fixed bits come from parameters, never from stored state
	function automatic logic [7:0] read_byte(input logic [7:0] addr, input bcc_regs_state_type s,
		input logic pgood);
		logic [7:0] r;
		r = BYTE_ZERO;
		if (addr == OFS_STANDBY) begin
			r = {FILL_STANDBY, s.standby_voltage_code};
		end else if (addr == OFS_FILLER) begin
			r = FILL_WHOLE;
		end else if (addr == OFS_CTRL) begin
			r = {FILL_CTRL, s.fault_unmask, pgood, s.enable};
		end else if (addr == OFS_NORMAL) begin
			r = {FILL_NORMAL, s.range_select, s.normal_voltage_code};
		end
		return r;
	endfunction : read_byte

	assign scl_s = pins[SY_SCL];
	assign sda_s = pins[SY_SDA];
	assign scl_rise = scl_s & ~q.scl_d1;
	assign scl_fall = ~scl_s & q.scl_d1;
	assign start_seen = scl_s & q.scl_d1 & ~sda_s & q.sda_d1;
	assign stop_seen = scl_s & q.scl_d1 & sda_s & ~q.sda_d1;
	// pgood is a comparator level; the 6% threshold lives in the analog loop
	assign rd_now = read_byte(q.ptr, q, pins[SY_PGOOD]);

	always_comb begin
		d = q;
		d.scl_d1 = scl_s;
		d.sda_d1 = sda_s;
		d.sda_out = 1'h0;
		if (stop_seen) begin
			d.st = ST_IDLE;
			d.sda_oe = 1'h0;
		end else if (start_seen) begin
			d.st = ST_ADDR;
			d.cnt = CNT_ZERO;
			d.sda_oe = 1'h0;
		end else begin
			case (q.st)
				ST_IDLE: begin
					d.sda_oe = 1'h0;
				end
				ST_ADDR: begin
					if (scl_rise) begin
						d.sr = {q.sr[6:0], sda_s};
						d.cnt = q.cnt + CNT_ONE;
					end else if (scl_fall && q.cnt == BITS_PER_BYTE) begin
						if (q.sr[7:1] == I2C_ADDR) begin
							d.rw = q.sr[0];
							d.sda_oe = 1'h1;
							d.st = ST_AACK;
						end else begin
							d.st = ST_IDLE;
						end
					end
				end
				ST_AACK: begin
					if (scl_fall) begin
						d.cnt = CNT_ZERO;
						if (q.rw) begin
							d.sr = rd_now;
							d.sda_oe = ~rd_now[7];
							d.st = ST_READ;
						end else begin
							d.sda_oe = 1'h0;
							d.ptr_done = 1'h0;
							d.st = ST_WRITE;
						end
					end
				end
				ST_WRITE: begin
					if (scl_rise) begin
						d.sr = {q.sr[6:0], sda_s};
						d.cnt = q.cnt + CNT_ONE;
					end else if (scl_fall && q.cnt == BITS_PER_BYTE) begin
						d.sda_oe = 1'h1;
						d.st = ST_WACK;
						if (!q.ptr_done) begin
							d.ptr = q.sr;
							d.ptr_done = 1'h1;
						end else begin
							d.ptr = q.ptr + PTR_ONE;
							// only writable fields are taken; fixed bits are dropped
							if (q.ptr == OFS_STANDBY) begin
								d.standby_voltage_code = q.sr[CODE_W-1:0];
							end else if (q.ptr == OFS_CTRL) begin
								d.enable = q.sr[BIT_ENABLE];
								d.fault_unmask = q.sr[BIT_UNMASK];
							end else if (q.ptr == OFS_NORMAL) begin
								d.normal_voltage_code = q.sr[CODE_W-1:0];
								d.range_select = q.sr[BIT_RANGE];
							end
						end
					end
				end
				ST_WACK: begin
					if (scl_fall) begin
						d.sda_oe = 1'h0;
						d.cnt = CNT_ZERO;
						d.st = ST_WRITE;
					end
				end
				ST_READ: begin
					if (scl_rise) begin
						d.cnt = q.cnt + CNT_ONE;
					end else if (scl_fall) begin
						if (q.cnt == BITS_PER_BYTE) begin
							d.sda_oe = 1'h0;
							d.ptr = q.ptr + PTR_ONE;
							d.st = ST_RACK;
						end else begin
							d.sr = {q.sr[6:0], 1'h0};
							d.sda_oe = ~q.sr[6];
						end
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						d.nack = sda_s;
					end else if (scl_fall) begin
						d.cnt = CNT_ZERO;
						if (q.nack) begin
							d.st = ST_IDLE;
						end else begin
							d.sr = rd_now;
							d.sda_oe = ~rd_now[7];
							d.st = ST_READ;
						end
					end
				end
				default: begin
					d.st = ST_IDLE;
					d.sda_oe = 1'h0;
				end
			endcase
		end
		// ch_on, code, range and unmask track the stored fields one edge after they land; mv and adj three edges after
		d.ch_on = q.enable & pins[SY_EXTEN];
		if (pins[SY_VOLTAGE_SELECT_PIN]) begin
			d.code_out = q.standby_voltage_code;
		end else begin
			d.code_out = q.normal_voltage_code;
		end
		d.range_out = q.range_select;
		d.unmask_out = q.fault_unmask;
		d.mv = dec_bus.mv;
		d.adj = dec_bus.adjustable;
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			q <= '{
				st: ST_IDLE,
				cnt: CNT_ZERO,
				sr: BYTE_ZERO,
				ptr: BYTE_ZERO,
				rw: 1'h0,
				ptr_done: 1'h0,
				nack: 1'h0,
				scl_d1: 1'h0,
				sda_d1: 1'h0,
				sda_oe: 1'h0,
				sda_out: 1'h0,
				standby_voltage_code: STANDBY_RESET,
				normal_voltage_code: NORMAL_RESET,
				range_select: RANGE_RESET,
				fault_unmask: UNMASK_RESET,
				enable: ENABLE_RESET,
				ch_on: 1'h0,
				code_out: NORMAL_RESET,
				range_out: RANGE_RESET,
				unmask_out: UNMASK_RESET,
				mv: MV_ZERO,
				adj: 1'h1
			};
		end else begin
			q <= d;
		end
	end

	assign SDA_OUT = q.sda_out;
	assign SDA_OE = q.sda_oe;
	assign CHANNEL_ON = q.ch_on;
	assign ACTIVE_VOLTAGE_CODE = q.code_out;
	assign RANGE_SELECT = q.range_out;
	assign FAULT_UNMASK = q.unmask_out;
	assign TARGET_MV = q.mv;
	assign ADJUSTABLE_MODE = q.adj;
endmodule : bcc_regs

// ===== bcc_pkg.sv
// shared constants, register map and types for the buck channel control bank
package bcc_pkg;
	localparam logic [7:0] OFS_STANDBY = 8'h30;
	localparam logic [7:0] OFS_FILLER = 8'h31;
	localparam logic [7:0] OFS_CTRL = 8'h32;
	localparam logic [7:0] OFS_NORMAL = 8'h33;
	localparam int CODE_W = 6;
	localparam int MV_W = 13;
	localparam int BIT_ENABLE = 0;
	localparam int BIT_PGOOD = 1;
	localparam int BIT_UNMASK = 2;
	localparam int BIT_RANGE = 6;
	localparam int CTRL_FILL_LSB = 3;
	localparam int STBY_FILL_LSB = 6;
	localparam int NORM_FILL_BIT = 7;
	localparam logic [CODE_W-1:0] CODE_ADJUSTABLE = 6'h00;
	localparam logic [CODE_W-1:0] CODE_FLAT_LAST = 6'h07;
	localparam logic [MV_W-1:0] LOW_MIN_MV = 13'h0320;
	localparam logic [MV_W-1:0] STEP_MV = 13'h0019;
	localparam logic [MV_W-1:0] MV_ZERO = 13'h0000;
	localparam logic [6:0] I2C_ADDR_DEFAULT = 7'h5A;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] CNT_ZERO = 4'h0;
	localparam logic [3:0] CNT_ONE = 4'h1;
	localparam logic [7:0] PTR_ONE = 8'h01;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam int SYNC_W = 5;
	localparam int SY_SCL = 0;
	localparam int SY_SDA = 1;
	localparam int SY_VOLTAGE_SELECT_PIN = 2;
	localparam int SY_EXTEN = 3;
	localparam int SY_PGOOD = 4;
	localparam logic [SYNC_W-1:0] SYNC_RESET = 5'h00;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ADDR = 3'h1,
		ST_AACK = 3'h2,
		ST_WRITE = 3'h3,
		ST_WACK = 3'h4,
		ST_READ = 3'h5,
		ST_RACK = 3'h6
	} bcc_i2c_state_type;
endpackage : bcc_pkg

// ===== bcc_dec_if.sv
// code-to-voltage request and answer between the bank and its decoder
`timescale 1ns/1ns
interface bcc_dec_if;
	import bcc_pkg::*;
	logic [CODE_W-1:0] code;
	logic range_select;
	logic [MV_W-1:0] mv;
	logic adjustable;
	modport requester (output code, output range_select, input mv, input adjustable);
	modport decoder (input code, input range_select, output mv, output adjustable);
endinterface : bcc_dec_if

// ===== bcc_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module bcc_sync
	import bcc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [SYNC_W-1:0] din,
	output logic [SYNC_W-1:0] dout
);
	typedef struct packed {
		logic [SYNC_W-1:0] s1;
		logic [SYNC_W-1:0] s2;
	} bcc_sync_state_type;

	bcc_sync_state_type q;
	bcc_sync_state_type d;

	always_comb begin
		d = q;
		d.s1 = din;
		d.s2 = q.s1;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q <= '{s1: SYNC_RESET, s2: SYNC_RESET};
		end else begin
			q <= d;
		end
	end

	assign dout = q.s2;
endmodule : bcc_sync

// ===== bcc_vdec.sv
// six-bit voltage code to millivolt decoder for the channel three bank
`timescale 1ns/1ns
module bcc_vdec
	import bcc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	bcc_dec_if.decoder dec
);
	typedef struct packed {
		logic [MV_W-1:0] mv;
		logic adjustable;
	} bcc_vdec_state_type;

	bcc_vdec_state_type q;
	bcc_vdec_state_type d;
	logic [MV_W-1:0] low_mv;
	logic [MV_W-1:0] lin_mv;
	logic [MV_W-1:0] steps;

	always_comb begin
		d = q;
		steps = MV_W'(dec.code) - MV_W'(CODE_FLAT_LAST);
		// wraps below code 7 on purpose; the sum stays positive for codes 1 to 7
		lin_mv = MV_W'(LOW_MIN_MV + MV_W'(steps * STEP_MV));
		low_mv = LOW_MIN_MV;
		if (dec.code > CODE_FLAT_LAST) begin
			low_mv = lin_mv;
		end
		d.adjustable = (dec.code == CODE_ADJUSTABLE);
		if (dec.code == CODE_ADJUSTABLE) begin
			d.mv = MV_ZERO;
		end else if (dec.range_select) begin
			// high range keeps its step below code 8, where the low range is clamped
			d.mv = MV_W'(lin_mv << 1);
		end else begin
			d.mv = low_mv;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q <= '{mv: MV_ZERO, adjustable: 1'h1};
		end else begin
			q <= d;
		end
	end

	assign dec.mv = q.mv;
	assign dec.adjustable = q.adjustable;
endmodule : bcc_vdec

// ===== bcc_regs_asserts.sv
// port-level checks for the buck channel control bank
`timescale 1ns/1ns
module bcc_regs_asserts
	import bcc_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RSTN,
	input wire logic SCL_IN,
	input wire logic VOLTAGE_SELECT_PIN,
	input wire logic EXTERNAL_CHANNEL_ENABLE,
	input wire logic CHANNEL_ON,
	input wire logic [CODE_W-1:0] ACTIVE_VOLTAGE_CODE,
	input wire logic RANGE_SELECT,
	input wire logic FAULT_UNMASK,
	input wire logic [MV_W-1:0] TARGET_MV,
	input wire logic ADJUSTABLE_MODE
);
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RSTN);
	wire logic [CODE_W-1:0] cd = ACTIVE_VOLTAGE_CODE;
	logic [2:0] calm_q;
	logic [CODE_W:0] seen_q;
	logic [MV_W-1:0] base_mv;
	logic [MV_W-1:0] high_mv;
	logic calm;
	// decoder lags the code, so only settled values are judged
	always_ff @(posedge SYS_CLK) begin
		seen_q <= {cd, RANGE_SELECT};
		if (!RSTN || {cd, RANGE_SELECT} != seen_q)
			calm_q <= 3'h0;
		else if (calm_q != 3'h7)
			calm_q <= calm_q + 3'h1;
	end
	// a code is unsettled in the very cycle it first shows
	assign calm = calm_q >= 3'h4 && {cd, RANGE_SELECT} == seen_q;
	always_comb begin
		base_mv = LOW_MIN_MV;
		if (cd > CODE_FLAT_LAST)
			base_mv = LOW_MIN_MV + STEP_MV * MV_W'(cd - CODE_FLAT_LAST);
		// high range steps by twice the low step all the way down to code 1
		high_mv = LOW_MIN_MV - STEP_MV * MV_W'(CODE_FLAT_LAST) + STEP_MV * MV_W'(cd);
		high_mv = MV_W'(high_mv << 1);
	end
	AST_MV_FLOOR: assert property (calm && !RANGE_SELECT &&
		cd inside {[6'h01:6'h07]} |-> TARGET_MV == LOW_MIN_MV) else $error("floor wrong");
	AST_MV_LOW: assert property (calm && !RANGE_SELECT &&
		cd > CODE_FLAT_LAST |-> TARGET_MV == base_mv) else $error("low range wrong");
	AST_MV_HIGH: assert property (calm && RANGE_SELECT &&
		cd != CODE_ADJUSTABLE |-> TARGET_MV == high_mv) else $error("high range wrong");
	AST_ADJ_ZERO: assert property (calm && cd == CODE_ADJUSTABLE |->
		ADJUSTABLE_MODE && TARGET_MV == MV_ZERO) else $error("adjustable code wrong");
	AST_ADJ_OFF: assert property (calm && cd != CODE_ADJUSTABLE |->
		!ADJUSTABLE_MODE) else $error("adjustable flag stuck");
	AST_ON_EXT: assert property (!EXTERNAL_CHANNEL_ENABLE [*4] |=>
		!CHANNEL_ON) else $error("channel on without external enable");
	AST_FIELD_AT_WRITE: assert property ($changed(RANGE_SELECT) ||
		$changed(FAULT_UNMASK) |-> !SCL_IN) else $error("field moved outside a write");
	AST_CODE_SWITCH: assert property ($changed(cd) |-> !SCL_IN ||
		$past(VOLTAGE_SELECT_PIN, 2) != $past(VOLTAGE_SELECT_PIN, 5)) else $error("code moved");
endmodule : bcc_regs_asserts
bind bcc_regs bcc_regs_asserts u_asserts (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .SCL_IN(SCL_IN),
	.VOLTAGE_SELECT_PIN(VOLTAGE_SELECT_PIN), .EXTERNAL_CHANNEL_ENABLE(EXTERNAL_CHANNEL_ENABLE),
	.CHANNEL_ON(CHANNEL_ON), .ACTIVE_VOLTAGE_CODE(ACTIVE_VOLTAGE_CODE),
	.RANGE_SELECT(RANGE_SELECT), .FAULT_UNMASK(FAULT_UNMASK), .TARGET_MV(TARGET_MV),
	.ADJUSTABLE_MODE(ADJUSTABLE_MODE));

// ===== bcc_host.sv
// i2c host model for the bank's serial port
`timescale 1ns/1ns
module bcc_host (
	input wire logic clk,
	input wire logic sda,
	output logic scl = 1'b1,
	output logic sda_pull = 1'b0
);
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#10;
	endtask : tick
	// data moves only while scl is low
	task automatic bit_io(input logic b, output logic s);
		sda_pull = !b;
		tick(4);
		scl = 1'b1;
		tick(8);
		s = sda;
		scl = 1'b0;
		tick(4);
	endtask : bit_io
	// from scl low this is a repeated start
	task automatic start();
		sda_pull = 1'b0;
		tick(4);
		scl = 1'b1;
		tick(8);
		sda_pull = 1'b1;
		tick(8);
		scl = 1'b0;
		tick(4);
	endtask : start
	task automatic stop();
		sda_pull = 1'b1;
		tick(4);
		scl = 1'b1;
		tick(8);
		sda_pull = 1'b0;
		tick(8);
	endtask : stop
	// a read sends all ones; last is the host's own ack bit
	task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
		output logic ack);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(last, ack);
	endtask : xfer
endmodule : bcc_host

// ===== test_buck_channel_control_regs.sv
// self-checking bench for the buck channel three control bank
`timescale 1ns/1ns
module test_buck_channel_control_regs;
	import bcc_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic voltage_select_pin = 1'b0;
	logic ext = 1'b1;
	logic pg = 1'b1;
	logic scl, pull, oe, on, rng, unm, adj, r, sdo;
	logic [CODE_W-1:0] code;
	logic [5:0] c;
	logic [MV_W-1:0] mv;
	wire sda = !(pull || oe);
	logic [15:0] exp_q[$];
	logic [15:0] got_v;
	event got_ev;
	int fail_count = 0;
	int num_checks = 0;
	int cyc = 0;
	logic [31:0] rnd = 32'h21;
	logic [5:0] cs[6] = '{6'h00, 6'h01, 6'h07, 6'h08, 6'h01, 6'h06};
	always #50 clk = !clk;
	bcc_regs dut (.SYS_CLK(clk), .RSTN(rstn), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sdo),
		.SDA_OE(oe), .VOLTAGE_SELECT_PIN(voltage_select_pin), .EXTERNAL_CHANNEL_ENABLE(ext),
		.POWER_GOOD_IN(pg), .CHANNEL_ON(on), .ACTIVE_VOLTAGE_CODE(code), .RANGE_SELECT(rng),
		.FAULT_UNMASK(unm), .TARGET_MV(mv), .ADJUSTABLE_MODE(adj));
	bcc_host host (.clk(clk), .sda(sda), .scl(scl), .sda_pull(pull));
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : print_verdict
	always @(got_ev) begin
		num_checks++;
		if (got_v !== exp_q[0]) begin
			fail_count++;
			$display("mismatch at %0t got %h expected %h", $time, got_v, exp_q[0]);
		end
		void'(exp_q.pop_front());
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			fail_count++;
			print_verdict();
		end
	end
	task automatic chk(input logic [15:0] e, input logic [15:0] g);
		exp_q.push_back(e);
		got_v = g;
		->got_ev;
		@(posedge clk);
		#10;
	endtask : chk
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xs
	function automatic logic [15:0] mv_of(input logic [5:0] k, input logic hi);
		logic [15:0] v;
		v = (k > 6'h07) ? 16'h0320 + 16'h0019 * (16'(k) - 16'h0007) : 16'h0320;
		// high range has no flat floor: 1300 mV at code 1, 50 mV a step
		if (hi)
			v = 16'h04E2 + 16'h0032 * 16'(k);
		if (k == 6'h00)
			v = 16'h0000;
		return v;
	endfunction : mv_of
	task automatic pins(input logic v, input logic e, input logic p);
		voltage_select_pin = v;
		ext = e;
		pg = p;
		repeat (8) @(posedge clk);
		#10;
	endtask : pins
	task automatic wr(input logic [7:0] p, input logic [7:0] d, input int n);
		logic [7:0] q;
		logic a;
		host.start();
		host.xfer({I2C_ADDR_DEFAULT, 1'b0}, 1'b1, q, a);
		chk(16'h0000, 16'(a));
		host.xfer(p, 1'b1, q, a);
		for (int i = 0; i < n; i++)
			host.xfer(d, 1'b1, q, a);
		chk(16'h0000, 16'(a));
		host.stop();
	endtask : wr
	task automatic rd(input logic [7:0] p, input logic [7:0] e);
		logic [7:0] q;
		logic a;
		host.start();
		host.xfer({I2C_ADDR_DEFAULT, 1'b0}, 1'b1, q, a);
		host.xfer(p, 1'b1, q, a);
		host.start();
		host.xfer({I2C_ADDR_DEFAULT, 1'b1}, 1'b1, q, a);
		host.xfer(8'hFF, 1'b1, q, a);
		host.stop();
		chk({8'h00, e}, {8'h00, q});
	endtask : rd
	initial begin
		repeat (12) @(posedge clk);
		#10;
		rstn = 1'b1;
		pins(1'b0, 1'b1, 1'b1);
		rd(OFS_STANDBY, 8'h00);
		rd(OFS_FILLER, 8'h00);
		rd(OFS_CTRL, 8'h02);
		rd(OFS_NORMAL, 8'h00);
		chk(16'h0000, 16'(sdo));
		$display("test reset images done");
		wr(OFS_STANDBY, 8'hFF, 4);
		rd(OFS_STANDBY, 8'h3F);
		rd(OFS_FILLER, 8'h00);
		rd(OFS_CTRL, 8'h07);
		rd(OFS_NORMAL, 8'h7F);
		chk(16'h0001, 16'(on));
		chk(16'h0001, 16'(unm));
		chk(16'h1130, 16'(mv));
		$display("test all ones burst done");
		pins(1'b0, 1'b0, 1'b0);
		chk(16'h0000, 16'(on));
		rd(OFS_CTRL, 8'h05);
		pins(1'b0, 1'b1, 1'b1);
		chk(16'h0001, 16'(on));
		$display("test enable and power good done");
		for (int i = 0; i < 12; i++) begin
			rnd = xs(rnd);
			c = (i < 6) ? cs[i] : rnd[5:0];
			r = (i < 6) ? (i > 3) : rnd[6];
			// code and range land in one write, so no stray voltage is passed
			wr(OFS_NORMAL, {1'b0, r, c}, 1);
			chk({10'h000, c}, 16'(code));
			chk(mv_of(c, r), 16'(mv));
			chk(16'(c == 6'h00), 16'(adj));
			chk(16'(r), 16'(rng));
		end
		pins(1'b1, 1'b1, 1'b1);
		chk(16'h003F, 16'(code));
		chk(mv_of(6'h3F, r), 16'(mv));
		pins(1'b0, 1'b1, 1'b1);
		$display("test voltage codes done");
		print_verdict();
	end
endmodule : test_buck_channel_control_regs
